// ---- verilog/pscr_defs.svh ----
// offsets, field positions, reset values and timing counts of the phy specific control block
`ifndef PSCR_DEFS_SVH
`define PSCR_DEFS_SVH
`define PSCR_ADDR_CTRL      5'h11
`define PSCR_ADDR_EVT_STAT  5'h18
`define PSCR_ADDR_EVT_MASK  5'h19
`define PSCR_ADDR_STATUS    5'h1a
`define PSCR_BIT_CLK_OFF    15
`define PSCR_BIT_PS_EN      14
`define PSCR_BIT_PS_HI      13
`define PSCR_BIT_PS_LO      12
`define PSCR_BIT_SCR_BYP    11
`define PSCR_BIT_DEPTH_HI   9
`define PSCR_BIT_DEPTH_LO   8
`define PSCR_BIT_COL_FD     4
`define PSCR_BIT_INTERRUPT_POLARITY    3
`define PSCR_BIT_TEST_INT   2
`define PSCR_BIT_INT_EN     1
`define PSCR_BIT_PIN_OUT    0
`define PSCR_CTRL_RESET     16'h0108
`define PSCR_CTRL_WMASK     16'hfb1f
`define PSCR_EVT_LINK_UP    0
`define PSCR_EVT_WAKE       1
`define PSCR_EVT_NLP        2
`define PSCR_CLK_MHZ        200
`define PSCR_NLP_PERIOD_MS  1400
`define PSCR_NLP_CYCLES     (`PSCR_NLP_PERIOD_MS * 1000 * `PSCR_CLK_MHZ)
`endif

// ---- verilog/pscr_pkg.sv ----
// types of the phy specific control block
package pscr_pkg;
	typedef enum logic [1:0] {
		PSCR_PS_NORMAL  = 2'b00,
		PSCR_PS_PWRDOWN = 2'b01,
		PSCR_PS_ACTIVE  = 2'b10,
		PSCR_PS_PASSIVE = 2'b11
	} pscr_ps_mode_t;

	typedef enum logic [1:0] {
		PSCR_ST_RUN   = 2'b00,
		PSCR_ST_DOWN  = 2'b01,
		PSCR_ST_SLEEP = 2'b10
	} pscr_state_t;

	typedef struct packed {
		logic          clk_off;
		logic          ps_en;
		pscr_ps_mode_t ps_mode;
		logic          scr_byp;
		logic [1:0]    depth;
		logic          col_fd;
		logic          interrupt_polarity;
		logic          test_int;
		logic          int_en;
		logic          pin_out;
	} pscr_ctrl_t;

	typedef struct packed {
		logic [4:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} pscr_req_t;

	typedef struct packed {
		logic        core_on;
		logic        clocks_on;
		logic        energy_det_on;
		logic        nlp_send;
		logic        scr_bypass;
		logic [3:0]  lb_depth;
		logic        col_out;
	} pscr_phy_t;

	typedef struct packed {
		pscr_ctrl_t  ctrl;
		pscr_state_t state;
		logic [2:0]  evt_stat;
		logic [2:0]  evt_mask;
		logic [31:0] nlp_cnt;
		logic        nlp_send;
		logic [15:0] rdata;
		logic        pin_level;
		logic        pin_oe;
	} pscr_regs_t;
endpackage

// ---- verilog/pscr_ctrl.sv ----
// phy specific control register with power-save sequencing, interrupt pin and event registers
// Notes on behaviour
// - bit 15 stops internal clocks, only while ieee power-down is in force
// - bit 14 enables power-save modes; cleared means normal operation
// - mode 00 is normal operation, everything running
// - mode 01 is ieee power-down, only the management port alive
// - active sleep keeps management and energy detect, link pulse every 1.4 s
// - active sleep wakes automatically when a link partner is detected
// - bit 11 bypasses the scrambler
// - reserved bits 10 and 7:5 ignore writes and read zero
// - bits 9:8 set loopback fifo depth 4,5,6,8 nibbles, reset 01
// - loopback fifo absorbs receive versus transmit clock rate difference
// - bit 4 allows collision signalling in full duplex
// - with bit 4 clear, collision shows only in half duplex
// - bit 3 sets interrupt polarity, 1 idles high and pulls low
// - bit 2 forces an interrupt for testing
// - forced interrupt stays asserted while bit 2 stays set
// - bit 0 makes the shared pin an interrupt output, else power-down input
// - bit 1 globally enables event interrupts, each event needs its own enable
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`include "pscr_defs.svh"
module pscr_ctrl
	import pscr_pkg::*;
#(
	parameter int unsigned NLP_CYCLES = `PSCR_NLP_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [4:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	input  wire logic        energy_detect,
	input  wire logic        full_duplex,
	input  wire logic        collision_raw,
	input  wire logic [2:0]  event_in,
	output pscr_phy_t        phy,
	output logic             irq,
	input  wire logic        pin_in,
	output logic             pin_out,
	output logic             pin_oe,
	output logic             pin_powerdown
);

	pscr_regs_t r_reg;
	pscr_regs_t r_next;
	pscr_req_t  req;
	logic       ed_meta_reg;
	logic       ed_sync_reg;
	logic       pin_meta_reg;
	logic       pin_sync_reg;
	logic       int_active;

	assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	function automatic logic [3:0] depth_nibbles(input logic [1:0] code);
		case (code)
			2'b00:   depth_nibbles = 4'h4;
			2'b01:   depth_nibbles = 4'h5;
			2'b10:   depth_nibbles = 4'h6;
			default: depth_nibbles = 4'h8;
		endcase
	endfunction

	function automatic logic [15:0] ctrl_word(input pscr_ctrl_t c);
		ctrl_word = {c.clk_off, c.ps_en, c.ps_mode, c.scr_byp, 1'b0, c.depth, 3'b000,
			c.col_fd, c.interrupt_polarity, c.test_int, c.int_en, c.pin_out};
	endfunction

	// one decoder for writes and reset keeps the bit map in a single place
	function automatic pscr_ctrl_t ctrl_from_word(input logic [15:0] v);
		pscr_ctrl_t c;
		c          = '0;
		c.clk_off  = v[`PSCR_BIT_CLK_OFF];
		c.ps_en    = v[`PSCR_BIT_PS_EN];
		c.ps_mode  = pscr_ps_mode_t'(v[`PSCR_BIT_PS_HI:`PSCR_BIT_PS_LO]);
		c.scr_byp  = v[`PSCR_BIT_SCR_BYP];
		c.depth    = v[`PSCR_BIT_DEPTH_HI:`PSCR_BIT_DEPTH_LO];
		c.col_fd   = v[`PSCR_BIT_COL_FD];
		c.interrupt_polarity  = v[`PSCR_BIT_INTERRUPT_POLARITY];
		c.test_int = v[`PSCR_BIT_TEST_INT];
		c.int_en   = v[`PSCR_BIT_INT_EN];
		c.pin_out  = v[`PSCR_BIT_PIN_OUT];
		ctrl_from_word = c;
	endfunction

	// pins and analog detector are asynchronous to clk
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ed_meta_reg  <= 1'b0;
			ed_sync_reg  <= 1'b0;
			pin_meta_reg <= 1'b1;
			pin_sync_reg <= 1'b1;
		end else begin
			ed_meta_reg  <= energy_detect;
			ed_sync_reg  <= ed_meta_reg;
			pin_meta_reg <= pin_in;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// test interrupt is level: holds as long as bit 2 is set
	assign int_active = r_reg.ctrl.test_int | (r_reg.ctrl.int_en &
		|(r_reg.evt_stat & r_reg.evt_mask));

	always_comb begin
		logic [15:0] w;
		logic [15:0] cur;
		w      = 16'h0000;
		cur    = 16'h0000;
		r_next = r_reg;
		cur    = ctrl_word(r_reg.ctrl);
		r_next.rdata = 16'h0000;
		if (req.wr && req.addr == `PSCR_ADDR_CTRL) begin
			w = (req.wdata & `PSCR_CTRL_WMASK) | (cur & ~`PSCR_CTRL_WMASK);
			r_next.ctrl = ctrl_from_word(w);
		end
		if (req.wr && req.addr == `PSCR_ADDR_EVT_MASK)
			r_next.evt_mask = req.wdata[2:0];
		// clear by writing one; a new event in the same cycle wins
		if (req.wr && req.addr == `PSCR_ADDR_EVT_STAT)
			r_next.evt_stat = r_reg.evt_stat & ~req.wdata[2:0];
		r_next.evt_stat = r_next.evt_stat | event_in;

		// power state: field only counts while enable is set
		r_next.nlp_send = 1'b0;
		case (r_reg.state)
			PSCR_ST_RUN: begin
				if (r_reg.ctrl.ps_en && r_reg.ctrl.ps_mode == PSCR_PS_PWRDOWN)
					r_next.state = PSCR_ST_DOWN;
				else if (r_reg.ctrl.ps_en && r_reg.ctrl.ps_mode == PSCR_PS_ACTIVE) begin
					r_next.state   = PSCR_ST_SLEEP;
					r_next.nlp_cnt = 32'h0;
				end
			end
			PSCR_ST_DOWN: begin
				if (!r_reg.ctrl.ps_en || r_reg.ctrl.ps_mode != PSCR_PS_PWRDOWN)
					r_next.state = PSCR_ST_RUN;
			end
			PSCR_ST_SLEEP: begin
				if (ed_sync_reg) begin
					// auto wake: drop the mode so software sees normal again
					r_next.state        = PSCR_ST_RUN;
					r_next.ctrl.ps_mode = PSCR_PS_NORMAL;
					r_next.evt_stat[`PSCR_EVT_WAKE] = 1'b1;
				end else if (!r_reg.ctrl.ps_en || r_reg.ctrl.ps_mode != PSCR_PS_ACTIVE) begin
					r_next.state = PSCR_ST_RUN;
				end else if (r_reg.nlp_cnt >= NLP_CYCLES - 1) begin
					r_next.nlp_cnt  = 32'h0;
					r_next.nlp_send = 1'b1;
					r_next.evt_stat[`PSCR_EVT_NLP] = 1'b1;
				end else begin
					r_next.nlp_cnt = r_reg.nlp_cnt + 32'h1;
				end
			end
			default: r_next.state = PSCR_ST_RUN;
		endcase
		if (r_reg.state != PSCR_ST_RUN && r_next.state == PSCR_ST_RUN)
			r_next.evt_stat[`PSCR_EVT_LINK_UP] = 1'b1;

		if (req.rd) begin
			case (req.addr)
				`PSCR_ADDR_CTRL:     r_next.rdata = cur;
				`PSCR_ADDR_EVT_STAT: r_next.rdata = {13'h0000, r_reg.evt_stat};
				`PSCR_ADDR_EVT_MASK: r_next.rdata = {13'h0000, r_reg.evt_mask};
				`PSCR_ADDR_STATUS:   r_next.rdata = {13'h0000, irq, r_reg.state};
				default:             r_next.rdata = 16'h0000;
			endcase
		end

		// shared pin: interrupt output with programmable idle level
		r_next.pin_oe    = r_next.ctrl.pin_out;
		r_next.pin_level = r_next.ctrl.interrupt_polarity ^ int_active;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r_reg          <= '0;
			r_reg.ctrl     <= ctrl_from_word(`PSCR_CTRL_RESET);
			r_reg.state    <= PSCR_ST_RUN;
			r_reg.pin_level <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign rdata   = r_reg.rdata;
	assign irq     = int_active;
	assign pin_out = r_reg.pin_level;
	assign pin_oe  = r_reg.pin_oe;
	// pin works as active-low power-down input while not an output
	assign pin_powerdown = !r_reg.ctrl.pin_out && !pin_sync_reg;

	always_comb begin
		phy               = '0;
		phy.core_on       = (r_reg.state == PSCR_ST_RUN) && !pin_powerdown;
		phy.clocks_on     = !(r_reg.ctrl.clk_off && r_reg.state == PSCR_ST_DOWN);
		phy.energy_det_on = (r_reg.state == PSCR_ST_SLEEP);
		phy.nlp_send      = r_reg.nlp_send;
		phy.scr_bypass    = r_reg.ctrl.scr_byp;
		phy.lb_depth      = depth_nibbles(r_reg.ctrl.depth);
		phy.col_out       = collision_raw && (!full_duplex || r_reg.ctrl.col_fd);
	end

	a_depth_reset: assert property (@(posedge clk) $rose(rst_n) |-> phy.lb_depth == 4'h5)
		else $error("loopback depth not five after reset");
	a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rd) && $past(addr) == `PSCR_ADDR_CTRL |-> (rdata & 16'h04e0) == 16'h0000)
		else $error("reserved control bits read nonzero");
	a_clk_off_down: assert property (@(posedge clk) disable iff (!rst_n)
		!phy.clocks_on |-> r_reg.state == PSCR_ST_DOWN && r_reg.ctrl.clk_off)
		else $error("clocks off outside power-down");
	a_ps_disabled: assert property (@(posedge clk) disable iff (!rst_n)
		!r_reg.ctrl.ps_en ##1 !r_reg.ctrl.ps_en |-> r_reg.state == PSCR_ST_RUN)
		else $error("power save state without enable");
	a_collision_gate: assert property (@(posedge clk) disable iff (!rst_n)
		phy.col_out |-> collision_raw && (!full_duplex || r_reg.ctrl.col_fd))
		else $error("collision out in full duplex without enable");
	sequence s_test_set;
		r_reg.ctrl.test_int && r_reg.pin_oe;
	endsequence
	a_test_int_pin: assert property (@(posedge clk) disable iff (!rst_n)
		s_test_set ##1 r_reg.ctrl.test_int && r_reg.pin_oe |-> pin_out == !r_reg.ctrl.interrupt_polarity)
		else $error("test interrupt not shown on pin");
	a_wake_detect: assert property (@(posedge clk) disable iff (!rst_n)
		r_reg.state == PSCR_ST_SLEEP && ed_sync_reg |=> r_reg.state == PSCR_ST_RUN)
		else $error("no wake on energy detect");
	a_scr_bypass: assert property (@(posedge clk) disable iff (!rst_n)
		wr && addr == `PSCR_ADDR_CTRL |=> phy.scr_bypass == $past(wdata[`PSCR_BIT_SCR_BYP]))
		else $error("scrambler bypass not following write");
	a_down_core_off: assert property (@(posedge clk) disable iff (!rst_n)
		r_reg.state == PSCR_ST_DOWN |-> !phy.core_on && !phy.energy_det_on)
		else $error("core alive in power-down");
	a_irq_test: assert property (@(posedge clk) disable iff (!rst_n)
		r_reg.ctrl.test_int |-> irq)
		else $error("test interrupt not raised");

	// named steps shared by the write and wake checks
	sequence s_ctrl_write;
		wr && addr == `PSCR_ADDR_CTRL;
	endsequence
	sequence s_sleep_wake;
		r_reg.state == PSCR_ST_SLEEP && ed_sync_reg;
	endsequence

	a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
		!$past(rd) |-> rdata == 16'h0000)
		else $error("read data not zero outside read cycle");

	a_depth_read: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rd) && $past(addr) == `PSCR_ADDR_CTRL |-> rdata[9:8] == $past(r_reg.ctrl.depth))
		else $error("depth field not read back");

	a_depth_legal: assert property (@(posedge clk) disable iff (!rst_n)
		phy.lb_depth == 4'h4 || phy.lb_depth == 4'h5 || phy.lb_depth == 4'h6 || phy.lb_depth == 4'h8)
		else $error("loopback depth outside the four settings");

	a_depth_max: assert property (@(posedge clk) disable iff (!rst_n)
		r_reg.ctrl.depth == 2'b11 |-> phy.lb_depth == 4'h8)
		else $error("depth code three not eight nibbles");

	a_depth_min: assert property (@(posedge clk) disable iff (!rst_n)
		r_reg.ctrl.depth == 2'b00 |-> phy.lb_depth == 4'h4)
		else $error("depth code zero not four nibbles");

	a_depth_write: assert property (@(posedge clk) disable iff (!rst_n)
		s_ctrl_write |=> r_reg.ctrl.depth == $past(wdata[`PSCR_BIT_DEPTH_HI:`PSCR_BIT_DEPTH_LO]))
		else $error("depth field not following write");

	a_pol_write: assert property (@(posedge clk) disable iff (!rst_n)
		s_ctrl_write |=> r_reg.ctrl.interrupt_polarity == $past(wdata[`PSCR_BIT_INTERRUPT_POLARITY]))
		else $error("polarity bit not following write");

	a_core_run: assert property (@(posedge clk) disable iff (!rst_n)
		phy.core_on |-> r_reg.state == PSCR_ST_RUN)
		else $error("core on outside normal operation");

	a_sleep_core_off: assert property (@(posedge clk) disable iff (!rst_n)
		r_reg.state == PSCR_ST_SLEEP |-> !phy.core_on && phy.energy_det_on)
		else $error("active sleep not reduced to energy detect");

	a_energy_sleep: assert property (@(posedge clk) disable iff (!rst_n)
		phy.energy_det_on |-> r_reg.state == PSCR_ST_SLEEP)
		else $error("energy detect alone outside active sleep");

	a_nlp_sleep: assert property (@(posedge clk) disable iff (!rst_n)
		phy.nlp_send |-> $past(r_reg.state) == PSCR_ST_SLEEP)
		else $error("link pulse sent outside active sleep");

	a_nlp_single: assert property (@(posedge clk) disable iff (!rst_n)
		phy.nlp_send |=> !phy.nlp_send)
		else $error("link pulse longer than one cycle");

	a_nlp_event: assert property (@(posedge clk) disable iff (!rst_n)
		phy.nlp_send |-> r_reg.evt_stat[`PSCR_EVT_NLP])
		else $error("link pulse not logged");

	a_wake_mode_clear: assert property (@(posedge clk) disable iff (!rst_n)
		s_sleep_wake |=> r_reg.ctrl.ps_mode == PSCR_PS_NORMAL)
		else $error("mode not normal after wake");

	a_wake_event: assert property (@(posedge clk) disable iff (!rst_n)
		s_sleep_wake |=> r_reg.evt_stat[`PSCR_EVT_WAKE])
		else $error("wake not logged");

	a_run_ps_off: assert property (@(posedge clk) disable iff (!rst_n)
		r_reg.state == PSCR_ST_RUN && !r_reg.ctrl.ps_en |=> r_reg.state == PSCR_ST_RUN)
		else $error("left normal operation without enable");

	a_normal_stays: assert property (@(posedge clk) disable iff (!rst_n)
		r_reg.state == PSCR_ST_RUN && r_reg.ctrl.ps_mode == PSCR_PS_NORMAL |=> r_reg.state == PSCR_ST_RUN)
		else $error("left normal operation in normal mode");

	a_enter_down: assert property (@(posedge clk) disable iff (!rst_n)
		r_reg.state == PSCR_ST_RUN && r_reg.ctrl.ps_en && r_reg.ctrl.ps_mode == PSCR_PS_PWRDOWN
		|=> r_reg.state == PSCR_ST_DOWN)
		else $error("power-down not entered");

	a_enter_sleep: assert property (@(posedge clk) disable iff (!rst_n)
		r_reg.state == PSCR_ST_RUN && r_reg.ctrl.ps_en && r_reg.ctrl.ps_mode == PSCR_PS_ACTIVE
		|=> r_reg.state == PSCR_ST_SLEEP)
		else $error("active sleep not entered");

	a_leave_down: assert property (@(posedge clk) disable iff (!rst_n)
		r_reg.state == PSCR_ST_DOWN && !r_reg.ctrl.ps_en |=> r_reg.state == PSCR_ST_RUN)
		else $error("power-down held without enable");

	a_state_legal: assert property (@(posedge clk) disable iff (!rst_n)
		r_reg.state == PSCR_ST_RUN || r_reg.state == PSCR_ST_DOWN || r_reg.state == PSCR_ST_SLEEP)
		else $error("power state code unused");

	a_clk_on_up: assert property (@(posedge clk) disable iff (!rst_n)
		r_reg.state != PSCR_ST_DOWN |-> phy.clocks_on)
		else $error("clocks stopped outside power-down");

	a_scr_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!(wr && addr == `PSCR_ADDR_CTRL) |=> $stable(phy.scr_bypass))
		else $error("scrambler bypass changed without write");

	a_col_fd_pass: assert property (@(posedge clk) disable iff (!rst_n)
		collision_raw && r_reg.ctrl.col_fd |-> phy.col_out)
		else $error("collision dropped with full duplex enable");

	a_col_half: assert property (@(posedge clk) disable iff (!rst_n)
		collision_raw && !full_duplex |-> phy.col_out)
		else $error("collision dropped in half duplex");

	a_pin_level: assert property (@(posedge clk) disable iff (!rst_n)
		$stable(irq) |-> pin_out == (r_reg.ctrl.interrupt_polarity ^ irq))
		else $error("pin level disagrees with polarity");

	a_oe_follow: assert property (@(posedge clk) disable iff (!rst_n)
		pin_oe == r_reg.ctrl.pin_out)
		else $error("pin enable not following bit zero");

	a_pin_pd_out: assert property (@(posedge clk) disable iff (!rst_n)
		r_reg.ctrl.pin_out |-> !pin_powerdown)
		else $error("power-down seen while pin is an output");

	a_pd_core_off: assert property (@(posedge clk) disable iff (!rst_n)
		pin_powerdown |-> !phy.core_on)
		else $error("core alive under pin power-down");

	a_irq_needs_en: assert property (@(posedge clk) disable iff (!rst_n)
		!r_reg.ctrl.test_int && !r_reg.ctrl.int_en |-> !irq)
		else $error("interrupt without global enable");

	a_irq_masked: assert property (@(posedge clk) disable iff (!rst_n)
		!r_reg.ctrl.test_int && (r_reg.evt_stat & r_reg.evt_mask) == 3'b000 |-> !irq)
		else $error("interrupt from masked event");

	// every event bit is sticky until a one is written to it
	for (genvar gi = 0; gi < 3; gi++) begin : g_evt
		a_evt_set: assert property (@(posedge clk) disable iff (!rst_n)
			event_in[gi] |=> r_reg.evt_stat[gi])
			else $error("event not latched in status");
		a_evt_sticky: assert property (@(posedge clk) disable iff (!rst_n)
			r_reg.evt_stat[gi] && !(wr && addr == `PSCR_ADDR_EVT_STAT && wdata[gi]) |=> r_reg.evt_stat[gi])
			else $error("event status lost without a clear");
	end

endmodule

// ---- testbench/pscr_ctrl_tb.sv ----
// self-checking bench for the phy specific control block
`timescale 1ns/100ps
module pscr_ctrl_tb
	import pscr_pkg::*;
;
	logic        clk;
	logic        rst_n;
	logic [4:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        energy_detect;
	logic        full_duplex;
	logic        collision_raw;
	logic [2:0]  event_in;
	pscr_phy_t   phy;
	logic        irq;
	logic        pin_in;
	logic        pin_out;
	logic        pin_oe;
	logic        pin_powerdown;
	int          fails;
	int          n_tests;
	int          cyc;
	logic [15:0] d;

	// short pulse period keeps the sleep test brief
	pscr_ctrl #(.NLP_CYCLES(20)) u_pscr_ctrl (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .energy_detect(energy_detect), .full_duplex(full_duplex),
		.collision_raw(collision_raw), .event_in(event_in), .phy(phy), .irq(irq), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .pin_powerdown(pin_powerdown));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("tests=%0d fails=%0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wr_reg(input logic [4:0] a, input logic [15:0] v);
		@(posedge clk);
		wr <= 1'b1; addr <= a; wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [4:0] a, output logic [15:0] v);
		@(posedge clk);
		rd <= 1'b1; addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic t_fields();
		rd_reg(5'h11, d); chk(d, 16'h0108);
		chk(phy.lb_depth, 16'h0005);
		wr_reg(5'h11, 16'hffff); rd_reg(5'h11, d); chk(d, 16'hfb1f);
		wr_reg(5'h11, 16'h0800); wait_cyc(1); chk(phy.scr_bypass, 1);
		for (int i = 0; i < 4; i++) begin
			wr_reg(5'h11, 16'h0000 | (i << 8)); wait_cyc(1);
			chk(phy.lb_depth, (i == 3) ? 16'h0008 : 16'h0004 + i);
		end
		chk(phy.scr_bypass, 0);
		rd_reg(5'h05, d); chk(d, 16'h0000);
	endtask

	task automatic t_collision();
		collision_raw <= 1'b1; full_duplex <= 1'b1;
		wr_reg(5'h11, 16'h0108); wait_cyc(1); chk(phy.col_out, 0);
		full_duplex <= 1'b0; wait_cyc(1); chk(phy.col_out, 1);
		full_duplex <= 1'b1; wr_reg(5'h11, 16'h0118); wait_cyc(1); chk(phy.col_out, 1);
		collision_raw <= 1'b0; wait_cyc(1); chk(phy.col_out, 0);
	endtask

	task automatic t_power();
		wr_reg(5'h11, 16'h1108); wait_cyc(3); chk(phy.core_on, 1);
		wr_reg(5'h11, 16'hc108); wait_cyc(3); chk({phy.core_on, phy.clocks_on}, 16'h3);
		wr_reg(5'h11, 16'h5108); wait_cyc(3); chk({phy.core_on, phy.clocks_on}, 16'h1);
		rd_reg(5'h1a, d); chk(d, 16'h0001);
		wr_reg(5'h11, 16'hd108); wait_cyc(3); chk(phy.clocks_on, 0);
		wr_reg(5'h11, 16'h0108); wait_cyc(3); chk({phy.core_on, phy.clocks_on}, 16'h3);
	endtask

	task automatic t_sleep();
		int n;
		n = 0;
		wr_reg(5'h11, 16'h6108); wait_cyc(3);
		chk({phy.core_on, phy.energy_det_on}, 16'h1);
		repeat (45) begin
			@(posedge clk); #1;
			if (phy.nlp_send === 1'b1) n++;
		end
		chk(n >= 2 && n <= 3, 1);
		energy_detect <= 1'b1;
		for (int i = 0; i < 10 && phy.core_on !== 1'b1; i++) wait_cyc(1);
		chk(phy.core_on, 1);
		rd_reg(5'h11, d); chk(d, 16'h4108);
		energy_detect <= 1'b0;
	endtask

	task automatic t_irq();
		// events from the power tests are still latched
		wr_reg(5'h18, 16'h0007);
		wr_reg(5'h11, 16'h010d); wait_cyc(2);
		chk({irq, pin_oe, pin_out}, 16'h6);
		wait_cyc(10); chk(irq, 1);
		wr_reg(5'h11, 16'h0105); wait_cyc(2); chk(pin_out, 1);
		wr_reg(5'h11, 16'h0101); wait_cyc(2); chk({irq, pin_out}, 16'h0);
		wr_reg(5'h19, 16'h0001); wr_reg(5'h11, 16'h0109);
		@(posedge clk) event_in <= 3'h1;
		@(posedge clk) event_in <= 3'h0;
		wait_cyc(2); chk(irq, 0);
		wr_reg(5'h11, 16'h010b); wait_cyc(2); chk({irq, pin_out}, 16'h2);
		wr_reg(5'h18, 16'h0001); wait_cyc(2); chk(irq, 0);
		@(posedge clk) event_in <= 3'h2;
		@(posedge clk) event_in <= 3'h0;
		wait_cyc(2); chk(irq, 0);
		rd_reg(5'h18, d); chk(d, 16'h0002);
		wr_reg(5'h18, 16'h0002);
	endtask

	task automatic t_pin();
		// pin is synchronised, so allow it a few cycles to land
		wr_reg(5'h11, 16'h0108); pin_in <= 1'b0; wait_cyc(4);
		chk({pin_oe, pin_powerdown}, 16'h1);
		chk(phy.core_on, 0);
		pin_in <= 1'b1; wait_cyc(4); chk(pin_powerdown, 0);
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			fails++;
			results();
		end
	end

	initial begin
		fails = 0; n_tests = 0; cyc = 0;
		rst_n = 1'b0; addr = 5'h00; wdata = 16'h0000; wr = 1'b0; rd = 1'b0;
		energy_detect = 1'b0; full_duplex = 1'b0; collision_raw = 1'b0; event_in = 3'h0; pin_in = 1'b1;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_fields();
		t_collision();
		t_power();
		t_sleep();
		t_irq();
		t_pin();
		results();
	end
endmodule
